//--- core/pswcb_consts.svh
// Offsets, field positions and reset values of the bank F configuration registers
`ifndef PSWCB_CONSTS_SVH
`define PSWCB_CONSTS_SVH
`define PSWCB_BANK_F 4'hf
`define PSWCB_OFF_PORTCFG 4'h0
`define PSWCB_OFF_SMR 4'hb
`define PSWCB_OFF_STOP_RECOVERY_CONTROL_TWO 4'hd
`define PSWCB_OFF_WDMODE 4'hf
`define PSWCB_PORTCFG_RST 8'hfe
`define PSWCB_SMR_RST 7'h20
`define PSWCB_STOP_RECOVERY_CONTROL_TWO_RST 2'h0
`define PSWCB_WDMODE_RST 5'h0d
`define PSWCB_BIT_OSC 7
`define PSWCB_BIT_P3DRV 6
`define PSWCB_BIT_P2DRV 5
`define PSWCB_BIT_P0DRV 3
`define PSWCB_BIT_P0PP 2
`define PSWCB_BIT_CMPOUT 0
`define PSWCB_BIT_LEVEL 6
`define PSWCB_BIT_DELAY 5
`define PSWCB_SRC_HI 4
`define PSWCB_SRC_LO 2
`define PSWCB_BIT_NODIV2 1
`define PSWCB_BIT_DIV16 0
`define PSWCB_BIT_WDCLK 4
`define PSWCB_BIT_WDSTOP 3
`define PSWCB_BIT_WDHALT 2
`define PSWCB_TAP0 12'd128
`define PSWCB_TAP1 12'd256
`define PSWCB_TAP2 12'd512
`define PSWCB_TAP3 12'd2048
`endif

//--- core/pswcb_pkg.sv
// Types of the bank F configuration block
package pswcb_pkg;
    typedef enum logic [2:0] {
        PSWCB_SRC_POR = 3'h0, PSWCB_SRC_P30 = 3'h1, PSWCB_SRC_P31 = 3'h2, PSWCB_SRC_P32 = 3'h3,
        PSWCB_SRC_P33 = 3'h4, PSWCB_SRC_P27 = 3'h5, PSWCB_SRC_NOR4 = 3'h6, PSWCB_SRC_NOR8 = 3'h7
    } pswcb_src_t;
    typedef enum logic [1:0] {
        PSWCB_SRC2_POR = 2'h0, PSWCB_SRC2_AND4 = 2'h1, PSWCB_SRC2_AND8 = 2'h2, PSWCB_SRC2_RSVD = 2'h3
    } pswcb_src2_t;
endpackage

//--- core/pswcb_bank.sv
// Bank F configuration registers: port, stop recovery and watchdog mode
//
// Notes on behaviour
// R01 - Port config bit 7 selects oscillator drive, 0 low-EMI, 1 standard, reset 1.
// R02 - Bits 6,5,3 set port 3, 2, 0 drive, 0 low-EMI, reset 1.
// R03 - Bit 2 sets port 0 output: 0 open-drain, 1 push-pull, reset 1.
// R04 - Software writes 1 to reserved port config bits 4 and 1.
// R05 - Bit 0 routes comparator results onto two port 3 pins, reset 0.
// R06 - Stop recovery bit 7 reads 0 after power-on, 1 after stop recovery.
// R07 - Stop recovery bit 6 selects wake level, 0 low, 1 high, reset 0.
// R08 - Stop recovery bit 5 enables the recovery delay, reset 1.
// R09 - Stop recovery bits 4..2 select wake source from port 3 or port 2.
// R10 - Wake source field cleared by reset and by stop recovery.
// R11 - Stop recovery bit 1: 0 divides clocks by two, 1 undivided, reset 0.
// R12 - Stop recovery bit 0 adds divide-by-16 of clocks, reset 0.
// R13 - Using first source field, software keeps second source field zero.
// R14 - Using second source field, software keeps first source field zero.
// R15 - Stop recovery resets to 20h; top bit read-only, rest write-only.
// R16 - Second stop recovery bits 1..0 select AND wake sources, reset 00.
// R17 - Second stop recovery is write-only; bits 7..2 written as zero.
// R18 - Watchdog mode write-only, low five bits reset 01101, upper bits indeterminate.
// R19 - Watchdog bit 4 selects clock: 0 internal RC, 1 crystal input.
// R20 - Watchdog bit 3 keeps it counting in stop mode, reset 1.
// R21 - Watchdog bit 2 keeps it counting in halt mode, reset 1.
// R22 - Watchdog bits 1..0 select timeout of 128, 256, 512, 2048 clocks.
// R23 - Contents survive stop recovery; only full reset restores reset values. Stop recovery here clears the wake source field and sets the stop flag.
// R24 - Software selects bank F through the register pointer low nibble.
// R25 - Write-only bits read unspecified; a write updates all fields at once.
`timescale 1ns/100ps
`include "pswcb_consts.svh"

module pswcb_bank (
    input wire logic clk, // System clock
    input wire logic rst, // Full reset, async high
    input wire logic [3:0] register_pointer_bank, // Low nibble of register pointer
    input wire logic [3:0] reg_addr, // Working register offset
    input wire logic reg_wr, // Write strobe
    input wire logic reg_rd, // Read strobe
    input wire logic [7:0] reg_wdata, // Write data
    output logic [7:0] reg_rdata, // Read data
    input wire logic stop_recovered, // One-cycle stop recovery pulse
    input wire logic [3:0] port3_pins, // Port 3 pins 0..3
    input wire logic [7:0] port2_pins, // Port 2 pins
    output logic osc_standard, // Oscillator drive standard
    output logic port3_standard, // Port 3 drive standard
    output logic port2_standard, // Port 2 drive standard
    output logic port0_standard, // Port 0 drive standard
    output logic port0_push_pull, // Port 0 push-pull
    output logic comparator_route, // Comparators to port3_bit4_pin/port3_bit7_pin
    output logic stop_flag, // Recovered from stop
    output logic wake_level_high, // Wake level high
    output logic stop_delay_on, // Recovery delay enabled
    output pswcb_pkg::pswcb_src_t wake_source, // Wake source
    output pswcb_pkg::pswcb_src2_t wake_source_two, // Second wake source
    output logic wake_request, // Selected wake condition met
    output logic clk_undivided, // System/timer clock undivided
    output logic clk_div16, // Extra divide-by-16
    output logic watchdog_crystal, // Watchdog clocked by crystal_input
    output logic watchdog_in_stop, // Watchdog runs in stop
    output logic watchdog_in_halt, // Watchdog runs in halt
    output logic [11:0] watchdog_timeout // Timeout in system clocks
);

    ////////////////////////////////////////////////////////////////////////////
    // Decode

    function automatic logic hit(input logic [3:0] bank, input logic [3:0] addr, input logic [3:0] off);
        hit = (bank == `PSWCB_BANK_F) && (addr == off);
    endfunction

    logic [7:0] portcfg_q, portcfg_d;
    logic [6:0] smr_q, smr_d;
    logic smr_flag_q, smr_flag_d;
    logic [1:0] stop_recovery_control_two_q, stop_recovery_control_two_d;
    logic [4:0] wdmode_q, wdmode_d;
    logic [7:0] rdata_q, rdata_d;
    logic smr_read_now;
    assign smr_read_now = reg_rd && hit(register_pointer_bank, reg_addr, `PSWCB_OFF_SMR);
    logic [11:0] pins_in;
    logic [11:0] sync1_q, sync1_d;
    logic [11:0] sync2_q, sync2_d;
    logic [11:0] sync3_q, sync3_d;
    logic [11:0] filt_q, filt_d;
    logic [3:0] p3_all;
    logic [7:0] p2_all;

    ////////////////////////////////////////////////////////////////////////////
    // Register next values

    always_comb begin
        portcfg_d = portcfg_q;
        smr_d = smr_q;
        smr_flag_d = smr_flag_q;
        stop_recovery_control_two_d = stop_recovery_control_two_q;
        wdmode_d = wdmode_q;
        // R25 whole-register write
        if (reg_wr && hit(register_pointer_bank, reg_addr, `PSWCB_OFF_PORTCFG)) begin
            portcfg_d = reg_wdata;
        end
        if (reg_wr && hit(register_pointer_bank, reg_addr, `PSWCB_OFF_SMR)) begin
            smr_d = reg_wdata[6:0];
        end
        // R17 reserved bits dropped
        if (reg_wr && hit(register_pointer_bank, reg_addr, `PSWCB_OFF_STOP_RECOVERY_CONTROL_TWO)) begin
            stop_recovery_control_two_d = reg_wdata[1:0];
        end
        // R18 reserved bits dropped
        if (reg_wr && hit(register_pointer_bank, reg_addr, `PSWCB_OFF_WDMODE)) begin
            wdmode_d = reg_wdata[4:0];
        end
        // R10 source cleared on recovery, wins over write
        if (stop_recovered) begin
            smr_d[`PSWCB_SRC_HI:`PSWCB_SRC_LO] = 3'h0;
            // R06 flag set on recovery
            smr_flag_d = 1'b1;
        end
        // R15 only top bit readable
        rdata_d = 8'h00;
        if (reg_rd && hit(register_pointer_bank, reg_addr, `PSWCB_OFF_SMR)) begin
            rdata_d = {smr_flag_q, 7'h00};
        end
    end

    // R23 only full reset restores defaults
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            portcfg_q <= `PSWCB_PORTCFG_RST;
            smr_q <= `PSWCB_SMR_RST;
            smr_flag_q <= 1'b0;
            stop_recovery_control_two_q <= `PSWCB_STOP_RECOVERY_CONTROL_TWO_RST;
            wdmode_q <= `PSWCB_WDMODE_RST;
            rdata_q <= 8'h00;
        end else begin
            portcfg_q <= portcfg_d;
            smr_q <= smr_d;
            smr_flag_q <= smr_flag_d;
            stop_recovery_control_two_q <= stop_recovery_control_two_d;
            wdmode_q <= wdmode_d;
            rdata_q <= rdata_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers

    // Port 2 pins above port 3 pins, one chain for all
    assign pins_in = {port2_pins, port3_pins};

    always_comb begin
        sync1_d = pins_in;
        sync2_d = sync1_q;
        sync3_d = sync2_q;
        // Level moves only once second and third stages agree
        filt_d = (sync2_q & sync3_q) | (filt_q & (sync2_q | sync3_q));
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sync1_q <= 12'h000;
            sync2_q <= 12'h000;
            sync3_q <= 12'h000;
            filt_q <= 12'h000;
        end else begin
            sync1_q <= sync1_d;
            sync2_q <= sync2_d;
            sync3_q <= sync3_d;
            filt_q <= filt_d;
        end
    end
    assign {p2_all, p3_all} = filt_q;

    ////////////////////////////////////////////////////////////////////////////
    // Wake decode

    logic wake_raw;
    always_comb begin
        wake_raw = 1'b0;
        // R09 first source decode
        unique case (pswcb_pkg::pswcb_src_t'(smr_q[`PSWCB_SRC_HI:`PSWCB_SRC_LO]))
            pswcb_pkg::PSWCB_SRC_POR: wake_raw = 1'b0;
            pswcb_pkg::PSWCB_SRC_P30: wake_raw = p3_all[0] == smr_q[`PSWCB_BIT_LEVEL];
            pswcb_pkg::PSWCB_SRC_P31: wake_raw = p3_all[1] == smr_q[`PSWCB_BIT_LEVEL];
            pswcb_pkg::PSWCB_SRC_P32: wake_raw = p3_all[2] == smr_q[`PSWCB_BIT_LEVEL];
            pswcb_pkg::PSWCB_SRC_P33: wake_raw = p3_all[3] == smr_q[`PSWCB_BIT_LEVEL];
            pswcb_pkg::PSWCB_SRC_P27: wake_raw = p2_all[7] == smr_q[`PSWCB_BIT_LEVEL];
            pswcb_pkg::PSWCB_SRC_NOR4: wake_raw = (~|p2_all[3:0]) == smr_q[`PSWCB_BIT_LEVEL];
            pswcb_pkg::PSWCB_SRC_NOR8: wake_raw = (~|p2_all) == smr_q[`PSWCB_BIT_LEVEL];
        endcase
        // R16 second source decode; R13 R14 only one field in use
        unique case (pswcb_pkg::pswcb_src2_t'(stop_recovery_control_two_q))
            pswcb_pkg::PSWCB_SRC2_AND4: wake_raw = wake_raw | ((&p2_all[3:0]) == smr_q[`PSWCB_BIT_LEVEL]);
            pswcb_pkg::PSWCB_SRC2_AND8: wake_raw = wake_raw | ((&p2_all) == smr_q[`PSWCB_BIT_LEVEL]);
            default: wake_raw = wake_raw;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs

    logic [11:0] tap_cycles;
    always_comb begin
        // R22 timeout tap
        unique case (wdmode_q[1:0])
            2'h0: tap_cycles = `PSWCB_TAP0;
            2'h1: tap_cycles = `PSWCB_TAP1;
            2'h2: tap_cycles = `PSWCB_TAP2;
            2'h3: tap_cycles = `PSWCB_TAP3;
        endcase
    end

    // R01 R02 R03 R05 port configuration fields
    assign osc_standard = portcfg_q[`PSWCB_BIT_OSC];
    assign port3_standard = portcfg_q[`PSWCB_BIT_P3DRV];
    assign port2_standard = portcfg_q[`PSWCB_BIT_P2DRV];
    assign port0_standard = portcfg_q[`PSWCB_BIT_P0DRV];
    assign port0_push_pull = portcfg_q[`PSWCB_BIT_P0PP];
    assign comparator_route = portcfg_q[`PSWCB_BIT_CMPOUT];
    // R06 R07 R08 R11 R12 stop recovery fields
    assign stop_flag = smr_flag_q;
    assign wake_level_high = smr_q[`PSWCB_BIT_LEVEL];
    assign stop_delay_on = smr_q[`PSWCB_BIT_DELAY];
    assign wake_source = pswcb_pkg::pswcb_src_t'(smr_q[`PSWCB_SRC_HI:`PSWCB_SRC_LO]);
    assign wake_source_two = pswcb_pkg::pswcb_src2_t'(stop_recovery_control_two_q);
    assign wake_request = wake_raw;
    assign clk_undivided = smr_q[`PSWCB_BIT_NODIV2];
    assign clk_div16 = smr_q[`PSWCB_BIT_DIV16];
    // R19 R20 R21 watchdog fields
    assign watchdog_crystal = wdmode_q[`PSWCB_BIT_WDCLK];
    assign watchdog_in_stop = wdmode_q[`PSWCB_BIT_WDSTOP];
    assign watchdog_in_halt = wdmode_q[`PSWCB_BIT_WDHALT];
    assign watchdog_timeout = tap_cycles;
    assign reg_rdata = rdata_q;

    ////////////////////////////////////////////////////////////////////////////
    // Checks

    sequence recovery_s;
        stop_recovered;
    endsequence

    sequence smr_write_s;
        reg_wr && hit(register_pointer_bank, reg_addr, `PSWCB_OFF_SMR);
    endsequence

    flag_set_a: assert property (@(posedge clk) disable iff (rst) recovery_s |=> smr_flag_q) // R06
        else $error("stop flag not set after recovery");
    flag_hold_a: assert property (@(posedge clk) disable iff (rst) smr_flag_q |=> smr_flag_q) // R06
        else $error("stop flag cleared without reset");
    flag_idle_a: assert property (@(posedge clk) disable iff (rst) // R06
        (!stop_recovered && !smr_flag_q) |=> !smr_flag_q)
        else $error("stop flag set without recovery");
    src_clear_a: assert property (@(posedge clk) disable iff (rst) // R10
        recovery_s |=> smr_q[`PSWCB_SRC_HI:`PSWCB_SRC_LO] == 3'h0)
        else $error("wake source not cleared on recovery");
    rec_keep_a: assert property (@(posedge clk) disable iff (rst) // R10
        (smr_write_s and recovery_s) |=> smr_q[`PSWCB_BIT_LEVEL] == $past(reg_wdata[`PSWCB_BIT_LEVEL]))
        else $error("other stop fields lost on recovery write");
    smr_write_a: assert property (@(posedge clk) disable iff (rst) // R25
        (smr_write_s and !stop_recovered) |=> smr_q == $past(reg_wdata[`PSWCB_BIT_LEVEL:`PSWCB_BIT_DIV16]))
        else $error("stop recovery write lost");
    keep_cfg_a: assert property (@(posedge clk) disable iff (rst) // R23
        (recovery_s and !reg_wr) |=> $stable(portcfg_q))
        else $error("port config changed on recovery");
    cfg_hold_a: assert property (@(posedge clk) disable iff (rst) // R23
        (!reg_wr && !stop_recovered) |=>
        $stable(portcfg_q) && $stable(smr_q) && $stable(smr_flag_q) && $stable(stop_recovery_control_two_q) && $stable(wdmode_q))
        else $error("register changed without write");
    port_write_a: assert property (@(posedge clk) disable iff (rst) // R25
        (reg_wr && hit(register_pointer_bank, reg_addr, `PSWCB_OFF_PORTCFG)) |=> portcfg_q == $past(reg_wdata))
        else $error("port config write lost");
    bank_guard_a: assert property (@(posedge clk) disable iff (rst) // R24
        (reg_wr && register_pointer_bank != `PSWCB_BANK_F && !stop_recovered) |=>
        $stable(portcfg_q) && $stable(smr_q) && $stable(stop_recovery_control_two_q) && $stable(wdmode_q))
        else $error("foreign bank write changed a register");
    wd_write_a: assert property (@(posedge clk) disable iff (rst) // R18
        (reg_wr && hit(register_pointer_bank, reg_addr, `PSWCB_OFF_WDMODE)) |=> wdmode_q == $past(reg_wdata[4:0]))
        else $error("watchdog mode write lost");
    stop_recovery_control_two_write_a: assert property (@(posedge clk) disable iff (rst) // R16
        (reg_wr && hit(register_pointer_bank, reg_addr, `PSWCB_OFF_STOP_RECOVERY_CONTROL_TWO)) |=> stop_recovery_control_two_q == $past(reg_wdata[1:0]))
        else $error("second source write lost");
    tap_low_a: assert property (@(posedge clk) disable iff (rst) // R22
        wdmode_q[1:0] == 2'h0 |-> watchdog_timeout == `PSWCB_TAP0)
        else $error("watchdog shortest tap wrong");
    tap_mid_a: assert property (@(posedge clk) disable iff (rst) // R22
        wdmode_q[1:0] == 2'h1 |-> watchdog_timeout == `PSWCB_TAP1)
        else $error("watchdog second tap wrong");
    tap_two_a: assert property (@(posedge clk) disable iff (rst) // R22
        wdmode_q[1:0] == 2'h2 |-> watchdog_timeout == `PSWCB_TAP2)
        else $error("watchdog third tap wrong");
    tap_map_a: assert property (@(posedge clk) disable iff (rst) // R22
        wdmode_q[1:0] == 2'h3 |-> watchdog_timeout == `PSWCB_TAP3)
        else $error("watchdog tap wrong");
    read_flag_a: assert property (@(posedge clk) disable iff (rst) // R15
        smr_read_now |=> reg_rdata == {$past(smr_flag_q), 7'h00})
        else $error("stop flag read wrong");
    wo_read_a: assert property (@(posedge clk) disable iff (rst) // R25
        (reg_rd && !hit(register_pointer_bank, reg_addr, `PSWCB_OFF_SMR)) |=> reg_rdata == 8'h00)
        else $error("write-only read not zero");
    rd_idle_a: assert property (@(posedge clk) disable iff (rst) // R25
        !reg_rd |=> reg_rdata == 8'h00)
        else $error("read data held past one cycle");
    wake_none_a: assert property (@(posedge clk) disable iff (rst) // R09
        (smr_q[`PSWCB_SRC_HI:`PSWCB_SRC_LO] == pswcb_pkg::PSWCB_SRC_POR && stop_recovery_control_two_q == pswcb_pkg::PSWCB_SRC2_POR)
        |-> !wake_request)
        else $error("wake without a source");
    sync_agree_a: assert property (@(posedge clk) disable iff (rst) // R09
        ((filt_q ^ $past(filt_q)) & ($past(sync2_q) ^ $past(sync3_q))) == 12'h000)
        else $error("pin level moved before stages agreed");

endmodule

//--- tb/testbench.sv
// Self-checking bench for the bank F configuration registers
`timescale 1ns/100ps
module testbench;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic stop_recovered = 1'b0;
    logic [3:0] bnk = 4'hf;
    logic [3:0] reg_addr = 4'h0;
    logic [3:0] port3_pins = 4'h0;
    logic [7:0] reg_wdata = 8'h00;
    logic [7:0] port2_pins = 8'h00;
    logic [7:0] reg_rdata;
    logic osc_standard, port3_standard, port2_standard, port0_standard, port0_push_pull, comparator_route;
    logic stop_flag, wake_level_high, stop_delay_on, wake_request, clk_undivided, clk_div16;
    logic watchdog_crystal, watchdog_in_stop, watchdog_in_halt;
    logic [11:0] watchdog_timeout;
    pswcb_pkg::pswcb_src_t wake_source;
    pswcb_pkg::pswcb_src2_t wake_source_two;
    int num_errors = 0;
    int check_count = 0;
    // Rows: offset, write data, expected field view of that register
    // all codes and bits
    logic [27:0] rows [20] = '{28'h0_7e_006c, 28'h0_93_0081, 28'h0_5f_004d, 28'hb_00_0000, 28'hb_84_0004,
        28'hb_48_0048, 28'hb_2c_002c, 28'hb_10_0010, 28'hb_56_0056, 28'hb_39_0039, 28'hb_ff_007f,
        28'hb_20_0020, 28'hd_01_0001, 28'hd_02_0002, 28'hd_03_0003, 28'hd_00_0000, 28'hf_10_4080,
        28'hf_0d_3100, 28'hf_0a_2200, 28'hf_17_5800};

    always #5 clk = ~clk;

    pswcb_bank pswcb_bank_i (.clk(clk), .rst(rst), .register_pointer_bank(bnk), .reg_addr(reg_addr),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .stop_recovered(stop_recovered), .port3_pins(port3_pins), .port2_pins(port2_pins),
        .osc_standard(osc_standard), .port3_standard(port3_standard), .port2_standard(port2_standard),
        .port0_standard(port0_standard), .port0_push_pull(port0_push_pull), .comparator_route(comparator_route),
        .stop_flag(stop_flag), .wake_level_high(wake_level_high), .stop_delay_on(stop_delay_on),
        .wake_source(wake_source), .wake_source_two(wake_source_two), .wake_request(wake_request),
        .clk_undivided(clk_undivided), .clk_div16(clk_div16), .watchdog_crystal(watchdog_crystal),
        .watchdog_in_stop(watchdog_in_stop), .watchdog_in_halt(watchdog_in_halt),
        .watchdog_timeout(watchdog_timeout));

    ////////////////////////////////////////////////////////////////////////////////
    // Field view of one register, laid out by bit position; watchdog mode gives its three mode bits above the decoded 12-bit timeout
    function automatic logic [15:0] obs(input logic [3:0] a);
        case (a)
            4'h0: obs = {8'h00, osc_standard, port3_standard, port2_standard, 1'b0, port0_standard,
                port0_push_pull, 1'b0, comparator_route};
            4'hb: obs = {9'h000, wake_level_high, stop_delay_on, wake_source, clk_undivided, clk_div16};
            4'hd: obs = {14'h0000, wake_source_two};
            default: obs = {1'b0, watchdog_crystal, watchdog_in_stop, watchdog_in_halt, watchdog_timeout};
        endcase
    endfunction

    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        check_count++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic summarize();
        $display("checks %0d errors %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
        #1;
    endtask

    task automatic rd(input logic [3:0] a);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
    endtask

    task automatic pins(input logic [3:0] p3, input logic [7:0] p2);
        @(posedge clk);
        port3_pins <= p3;
        port2_pins <= p2;
    endtask

    task automatic wait_wake(input logic e);
        int i;
        for (i = 0; i < 12; i++) begin
            @(posedge clk);
            #1;
            if (wake_request === e) break;
        end
        chk("wake_request", {15'h0000, e}, {15'h0000, wake_request});
        if (wake_request !== e) summarize();
    endtask

    task automatic check_reset();
        chk("port_configuration", 16'h00ec, obs(4'h0));
        chk("stop_recovery_control", 16'h0020, obs(4'hb));
        chk("stop_recovery_control_two", 16'h0000, obs(4'hd));
        chk("watchdog_mode", 16'h3100, obs(4'hf));
        chk("stop_flag", 16'h0000, {15'h0000, stop_flag});
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        #1;
        check_reset();
        for (int i = 0; i < 20; i++) begin
            wr(rows[i][27:24], rows[i][23:16]);
            chk("row fields", rows[i][15:0], obs(rows[i][27:24]));
        end
        // Foreign bank and unused offset leave everything alone
        @(posedge clk);
        bnk <= 4'h0;
        wr(4'h0, 8'h00);
        @(posedge clk);
        bnk <= 4'hf;
        wr(4'h1, 8'h00);
        chk("ignored write", 16'h004d, obs(4'h0));
        rd(4'h0);
        chk("write-only read", 16'h0000, {8'h00, reg_rdata});
        // Wake on port 3 pin 0, high then low level
        wr(4'hb, 8'h44);
        pins(4'h1, 8'h00);
        wait_wake(1'b1);
        pins(4'h0, 8'h00);
        wait_wake(1'b0);
        wr(4'hb, 8'h04);
        wait_wake(1'b1);
        // Second source field in use, first kept at zero
        wr(4'hb, 8'h40);
        wr(4'hd, 8'h01);
        pins(4'h0, 8'h0f);
        wait_wake(1'b1);
        pins(4'h0, 8'h07);
        wait_wake(1'b0);
        wr(4'hd, 8'h02);
        wait_wake(1'b0);
        pins(4'h0, 8'hff);
        wait_wake(1'b1);
        // First source field in use, second kept at zero
        wr(4'hd, 8'h00);
        wr(4'hb, 8'h5c);
        wait_wake(1'b0);
        pins(4'h0, 8'h00);
        wait_wake(1'b1);
        wr(4'hb, 8'h54);
        wait_wake(1'b0);
        pins(4'h0, 8'h80);
        wait_wake(1'b1);
        // Stop recovery clears only the source field and raises the flag
        wr(4'hb, 8'h5b);
        @(posedge clk);
        stop_recovered <= 1'b1;
        @(posedge clk);
        stop_recovered <= 1'b0;
        #1;
        chk("source after stop", 16'h0043, obs(4'hb));
        chk("stop_flag", 16'h0001, {15'h0000, stop_flag});
        chk("port kept", 16'h004d, obs(4'h0));
        chk("watchdog kept", 16'h5800, obs(4'hf));
        // Write and recovery in one cycle: recovery still clears the source
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= 4'hb;
        reg_wdata <= 8'h7f;
        stop_recovered <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
        stop_recovered <= 1'b0;
        #1;
        chk("write during stop", 16'h0063, obs(4'hb));
        wr(4'hb, 8'h00);
        rd(4'hb);
        chk("flag read", 16'h0080, {8'h00, reg_rdata});
        @(posedge clk);
        #1;
        chk("read data drop", 16'h0000, {8'h00, reg_rdata});
        // Second full reset in mid-run
        @(posedge clk);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        #1;
        check_reset();
        @(posedge clk);
        rst <= 1'b0;
        wr(4'h0, 8'h7e);
        chk("write after reset", 16'h006c, obs(4'h0));
        summarize();
    end
endmodule
